// >>> mstl_engine.sv
// Test-mode engine: pseudorandom uplink (mode a) or downlink loopback (b).
// Assumes layer 1 gives decoded downlink octets and USF grants per slot.
//
// Notes on behaviour
// - Mode a or b is picked from the command's mode-select bit when both are supported; otherwise loop_capable picks it.
// - PDU count and octets per PDU from the command size the uplink.
// - While active, received data blocks are not passed up to LLC.
// - Mode a sends data blocks only in USF-granted block periods.
// - Mode a payload comes from the pseudorandom generator; MAC header valid.
// - Later uplink slots send one generator octet, unstepped, for every octet of the block.
// - Mode b payload repeats the source slot's last downlink data octet, or the held generator octet before one.
// - Mode b skips countdown; countdown value fixed at 15.
// - On a downlink control block, mode b may resend previous payload.
// - Mode b loops payload with bad CRC when USF was decoded and grants.
// - Mode b may drop looped payload when sending an uplink control block.
// - Downlink control blocks keep being handled as normal in both modes.
// - Mode a ends after the commanded PDUs or on TBF release.
// - Mode b ends on downlink TBF end or uplink PDCH release.
// - Payload generator has a period of at least 32767 bits.
// - Multislot: n-th downlink slot loops onto n-th uplink slot.
// - Surplus uplink slots repeat the last mapped uplink slot.
// - Single downlink slot: all uplink slots filled by basic rules.
// - Downlink count starts at offset slot, next active, wraps 7 to 0.
// - Uplink slot count always starts at slot zero.
`timescale 1ns/1ps
module mstl_engine
   import mstl_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire mstl_cmd_t cmd,
   input wire logic loop_capable,
   input wire logic prbs_capable,
   input wire logic [NUM_TN-1:0] dl_tbf_slots,
   input wire logic [NUM_TN-1:0] ul_tbf_slots,
   input wire logic dl_valid,
   input wire mstl_dl_t dl,
   input wire logic ul_grant,
   input wire logic [TN_W-1:0] ul_grant_tn,
   input wire logic ul_ctrl_send,
   input wire logic ul_ready,
   input wire logic tbf_release,
   input wire logic dl_tbf_end,
   input wire logic pdch_release,
   output logic test_active,
   output mstl_mode_t test_mode,
   output logic llc_pass_en,
   output logic ctrl_pass,
   output logic ul_valid,
   output mstl_ul_t ul,
   output logic test_done
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT,
      ST_SEND
   } mstl_state_t;

   mstl_state_t state;
   mstl_cmd_t cmd_q;
   logic [PDU_COUNT_W-1:0] pdus_left;
   logic [PDU_OCTETS_W-1:0] octet_idx;
   logic [PAYLOAD_W-1:0] loop_buf [0:NUM_TN-1][0:(1<<PDU_OCTETS_W)/256-1];
   logic [NUM_TN-1:0] buf_full;
   logic [TN_W-1:0] ul_tn;
   logic [TN_W-1:0] src_slot;
   logic [PAYLOAD_W-1:0] prbs_octet;
   logic prbs_step;
   logic [TN_W-1:0] dl_rank [0:NUM_TN-1];
   logic [TN_W-1:0] ul_rank [0:NUM_TN-1];
   logic [TN_W-1:0] rank_slot [0:NUM_TN-1];
   logic [TN_W-1:0] last_rank;
   logic multi_dl;
   logic end_event;
   logic send_beat;
   logic load_beat;
   logic [TN_W-1:0] buf_idx;

   ////////////////////////////////////////////////////////////////////////
   // Slot ranking

   // Downlink rank counted from the offset slot, wrapping 7 to 0
   always_comb begin
      logic [TN_W-1:0] cnt;
      logic [TN_W-1:0] tn;
      cnt = '0;
      tn = '0;
      last_rank = '0;
      for (int i = 0; i < NUM_TN; i++) begin
         dl_rank[i] = '0;
         rank_slot[i] = cmd_q.dl_tn_offset;
      end
      for (int k = 0; k < NUM_TN; k++) begin
         tn = cmd_q.dl_tn_offset + TN_W'(k);
         if (dl_tbf_slots[tn]) begin
            dl_rank[tn] = cnt;
            rank_slot[cnt] = tn;
            last_rank = cnt;
            cnt = cnt + 1'b1;
         end
      end
   end

   // Uplink rank always counted from slot zero
   always_comb begin
      logic [TN_W-1:0] cnt;
      cnt = '0;
      for (int i = 0; i < NUM_TN; i++) begin
         ul_rank[i] = cnt;
         if (ul_tbf_slots[i]) begin
            cnt = cnt + 1'b1;
         end
      end
   end

   assign multi_dl = cmd_q.multislot_en && (last_rank != '0);

   // Source downlink slot for the granted uplink slot
   always_comb begin
      if (!multi_dl) begin
         src_slot = rank_slot[0];
      end else if (ul_rank[ul_tn] > last_rank) begin
         src_slot = rank_slot[last_rank];
      end else begin
         src_slot = rank_slot[ul_rank[ul_tn]];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command, mode and termination

   assign end_event = (test_mode == MSTL_MODE_PRBS)
      ? (tbf_release || (state == ST_SEND && send_beat && ul.last
         && pdus_left == PDU_COUNT_W'(1)))
      : (dl_tbf_end || pdch_release);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         test_active <= 1'b0;
         test_mode <= MSTL_MODE_PRBS;
         cmd_q <= '0;
         llc_pass_en <= 1'b1;
         test_done <= 1'b0;
      end else begin
         test_done <= 1'b0;
         if (!test_active && cmd_valid) begin
            test_active <= 1'b1;
            cmd_q <= cmd;
            llc_pass_en <= 1'b0;
            if (prbs_capable && loop_capable) begin
               test_mode <= cmd.mode_select ? MSTL_MODE_LOOP
                  : MSTL_MODE_PRBS;
            end else begin
               test_mode <= loop_capable ? MSTL_MODE_LOOP : MSTL_MODE_PRBS;
            end
         end else if (test_active && end_event) begin
            test_active <= 1'b0;
            llc_pass_en <= 1'b1;
            test_done <= 1'b1;
         end
      end
   end

   // Control blocks always pass on to RLC/MAC
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_pass <= 1'b0;
      end else begin
         ctrl_pass <= dl_valid && dl.is_control;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Downlink capture for loopback

   assign buf_idx = dl.tn;

   always_ff @(posedge clk) begin
      if (test_active && dl_valid && !dl.is_control
            && test_mode == MSTL_MODE_LOOP) begin
         loop_buf[buf_idx][0] <= dl.data;
      end
   end

   // Payload kept on control blocks so the previous one repeats
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         buf_full <= '0;
      end else if (!test_active) begin
         buf_full <= '0;
      end else if (dl_valid && !dl.is_control) begin
         buf_full[buf_idx] <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Uplink sender

   assign send_beat = ul_valid && ul_ready;
   // Generator steps as each mode a octet for uplink rank 0 is loaded, so octets run contiguous
   assign load_beat = state == ST_SEND && test_active
      && (!ul_valid || ul_ready) && !(ul_valid && ul.last);
   assign prbs_step = load_beat && test_mode == MSTL_MODE_PRBS
      && ul_rank[ul_tn] == '0;

   mstl_prbs u_prbs (
      .clk(clk),
      .reset_n(reset_n),
      .step(prbs_step),
      .octet(prbs_octet)
   );

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         ul_valid <= 1'b0;
         ul <= '0;
         ul_tn <= '0;
         octet_idx <= '0;
         pdus_left <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               ul_valid <= 1'b0;
               if (!test_active && cmd_valid) begin
                  pdus_left <= cmd.pdu_count;
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!test_active) begin
                  state <= ST_IDLE;
               end else if (ul_grant && !ul_ctrl_send) begin
                  ul_tn <= ul_grant_tn;
                  octet_idx <= '0;
                  state <= ST_SEND;
               end else if (ul_grant) begin
                  state <= ST_WAIT;
               end
            end
            ST_SEND: begin
               if (!test_active) begin
                  ul_valid <= 1'b0;
                  state <= ST_IDLE;
               end else if (!ul_valid || ul_ready) begin
                  ul_valid <= 1'b1;
                  ul.tn <= ul_tn;
                  ul.data <= (test_mode == MSTL_MODE_LOOP)
                     ? (buf_full[src_slot] ? loop_buf[src_slot][0]
                        : prbs_octet)
                     : prbs_octet;
                  ul.cv <= (test_mode == MSTL_MODE_LOOP) ? CV_FROZEN
                     : (pdus_left > PDU_COUNT_W'(15) ? CV_FROZEN
                        : 4'(pdus_left - 1'b1));
                  ul.last <= octet_idx == cmd_q.pdu_octets - 1'b1;
                  octet_idx <= octet_idx + 1'b1;
                  if (ul_valid && ul.last) begin
                     ul_valid <= 1'b0;
                     if (test_mode == MSTL_MODE_PRBS) begin
                        pdus_left <= pdus_left - 1'b1;
                     end
                     state <= ST_WAIT;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   llc_blocked_a: assert property (@(posedge clk) disable iff (!reset_n)
      test_active |-> !llc_pass_en) else $error("LLC open in test");
   cv_frozen_a: assert property (@(posedge clk) disable iff (!reset_n)
      (ul_valid && test_mode == MSTL_MODE_LOOP) |-> ul.cv == CV_FROZEN)
      else $error("countdown moved in loop mode");
   send_needs_grant_a: assert property (@(posedge clk) disable iff (!reset_n)
      (state == ST_WAIT && !ul_grant) |=> state != ST_SEND)
      else $error("sent without grant");
   loop_end_a: assert property (@(posedge clk) disable iff (!reset_n)
      (test_active && test_mode == MSTL_MODE_LOOP && dl_tbf_end)
      |=> !test_active && test_done) else $error("loop not ended");
   prbs_end_a: assert property (@(posedge clk) disable iff (!reset_n)
      (test_active && test_mode == MSTL_MODE_PRBS && tbf_release)
      |=> !test_active)
      else $error("release ignored");
   ctrl_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
      (dl_valid && dl.is_control) |=> ctrl_pass)
      else $error("control block dropped");
   mode_pick_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!test_active && cmd_valid && prbs_capable && loop_capable)
      |=> test_mode == mstl_mode_t'($past(cmd.mode_select)))
      else $error("mode bit ignored");
   size_load_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!test_active && cmd_valid) |=> cmd_q.pdu_octets == $past(cmd.pdu_octets))
      else $error("size not taken");

   loop_run_c: cover property (@(posedge clk) disable iff (!reset_n)
      test_active && test_mode == MSTL_MODE_LOOP && send_beat);
   prbs_done_c: cover property (@(posedge clk) disable iff (!reset_n)
      test_done && test_mode == MSTL_MODE_PRBS);
   multi_map_c: cover property (@(posedge clk) disable iff (!reset_n)
      multi_dl && ul_grant && ul_rank[ul_grant_tn] > last_rank);

endmodule : mstl_engine

// >>> mstl_engine_test.sv
// Self-checking bench for the test-mode engine.
// Assumes mstl_sim_model plays the test equipment.
`timescale 1ns/1ps
module mstl_engine_test;
   import mstl_pkg::*;
   logic clk = 0, reset_n = 0, loop_capable = 1, prbs_capable = 1;
   logic ul_ready = 0;
   logic [7:0] dl_tbf_slots = 8'h28, ul_tbf_slots = 8'h07;
   logic cmd_valid, dl_valid, ul_grant, ul_ctrl_send, tbf_release;
   logic dl_tbf_end, pdch_release, test_active, llc_pass_en, ctrl_pass;
   logic ul_valid, test_done;
   logic [2:0] ul_grant_tn;
   mstl_cmd_t cmd;
   mstl_dl_t dl;
   mstl_ul_t ul;
   mstl_mode_t test_mode;
   int error_cnt = 0, n_compared = 0, done_cnt = 0, ctrl_cnt = 0, b;
   mstl_ul_t rx[$];
   logic [7:0] q[$];
   logic [3:0] cv;
   mstl_engine i_dut (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd(cmd), .loop_capable(loop_capable), .prbs_capable(prbs_capable),
      .dl_tbf_slots(dl_tbf_slots), .ul_tbf_slots(ul_tbf_slots),
      .dl_valid(dl_valid), .dl(dl), .ul_grant(ul_grant),
      .ul_grant_tn(ul_grant_tn), .ul_ctrl_send(ul_ctrl_send),
      .ul_ready(ul_ready), .tbf_release(tbf_release),
      .dl_tbf_end(dl_tbf_end), .pdch_release(pdch_release),
      .test_active(test_active), .test_mode(test_mode),
      .llc_pass_en(llc_pass_en), .ctrl_pass(ctrl_pass),
      .ul_valid(ul_valid), .ul(ul), .test_done(test_done));
   mstl_sim_model i_sim (.clk(clk), .test_active(test_active),
      .cmd_valid(cmd_valid), .cmd(cmd), .dl_valid(dl_valid), .dl(dl),
      .ul_grant(ul_grant), .ul_grant_tn(ul_grant_tn),
      .ul_ctrl_send(ul_ctrl_send), .tbf_release(tbf_release),
      .dl_tbf_end(dl_tbf_end), .pdch_release(pdch_release));
   always #4 clk = ~clk;
   always @(posedge clk) ul_ready <= #1 ~ul_ready;
   always @(posedge clk) begin
      if (ul_valid === 1'b1 && ul_ready) rx.push_back(ul);
      if (test_done === 1'b1) done_cnt++;
      if (ctrl_pass === 1'b1) ctrl_cnt++;
   end
   ////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   function automatic bit prbs_ok(input logic [7:0] p[$]);
      logic [0:159] m, l;
      bit ok[4];
      int n;
      ok = '{1, 1, 1, 1};
      for (n = 0; n < 160; n++) begin
         m[n] = p[n/8][7-n%8];
         l[n] = p[n/8][n%8];
      end
      for (n = 15; n < 160; n++) begin
         if (m[n] !== (m[n-14] ^ m[n-15])) ok[0] = 0;
         if (m[n] !== (m[n-1] ^ m[n-15])) ok[1] = 0;
         if (l[n] !== (l[n-14] ^ l[n-15])) ok[2] = 0;
         if (l[n] !== (l[n-1] ^ l[n-15])) ok[3] = 0;
      end
      return (|m) && !(&m) && (ok[0] | ok[1] | ok[2] | ok[3]);
   endfunction : prbs_ok
   task take_block(input logic [2:0] tn);
      int k;
      rx = {};
      q = {};
      i_sim.grant(tn, 1'b0);
      for (k = 0; k < 400 && !(rx.size() > 0 && rx[$].last); k++)
         @(posedge clk);
      #1;
      check(k < 400, 1);
      foreach (rx[i]) begin
         q.push_back(rx[i].data);
         check(rx[i].tn, tn);
      end
      cv = rx.size() > 0 ? rx[$].cv : 4'h0;
   endtask : take_block
   task settle(input int n);
      int k;
      repeat (2) @(posedge clk);
      for (k = 0; k < n && test_active !== 1'b0; k++) @(posedge clk);
      #1;
   endtask : settle
   ////////////////////////////////////////////////////////////////////
   initial begin
      #(8 * 20000);
      error_cnt++;
      close_out;
   end
   initial begin
      repeat (2) @(posedge clk);
      #1 reset_n = 1;
      check(llc_pass_en, 1);
      // Mode a, ended by the block count
      i_sim.send_cmd(1'b0, 3'h0, 1'b0, 16'h0003, 16'h0014, 0);
      @(posedge clk);
      #1;
      check(test_mode, MSTL_MODE_PRBS);
      check(llc_pass_en, 0);
      i_sim.send_dl(3'h3, 1'b1, 1'b1, 8'h5A);
      repeat (8) @(posedge clk);
      #1;
      check(ctrl_cnt, 1);
      check(rx.size(), 0);
      for (b = 0; b < 3; b++) begin
         take_block(3'h0);
         check(q.size(), 20);
         check(cv, 2 - b);
         check(prbs_ok(q), 1);
      end
      settle(50);
      check(test_active, 0);
      check(done_cnt, 1);
      check(llc_pass_en, 1);
      // Mode a, ended by TBF release
      i_sim.send_cmd(1'b0, 3'h0, 1'b0, 16'h0100, 16'h0014, 0);
      i_sim.end_pulse(0);
      settle(50);
      check(done_cnt, 2);
      // Mode b multislot, offset 4: TN5 first, then TN3
      i_sim.send_cmd(1'b1, 3'h4, 1'b1, 16'h0010, 16'h0001, 0);
      @(posedge clk);
      #1;
      check(test_mode, MSTL_MODE_LOOP);
      i_sim.send_dl(3'h5, 1'b0, 1'b1, 8'hA5);
      i_sim.send_dl(3'h3, 1'b0, 1'b0, 8'h3C);
      i_sim.send_cmd(1'b0, 3'h0, 1'b0, 16'h0001, 16'h0001, 1);
      @(posedge clk);
      #1;
      check(test_mode, MSTL_MODE_LOOP);
      rx = {};
      i_sim.grant(3'h0, 1'b1);
      repeat (8) @(posedge clk);
      #1;
      check(rx.size(), 0);
      take_block(3'h0);
      check(q[0], 8'hA5);
      check(cv, CV_FROZEN);
      take_block(3'h1);
      check(q[0], 8'h3C);
      take_block(3'h2);
      check(q[0], 8'h3C);
      i_sim.end_pulse(1);
      settle(50);
      check(done_cnt, 3);
      // Mode b from the loop strap alone, ended by channel release
      prbs_capable = 0;
      i_sim.send_cmd(1'b0, 3'h0, 1'b0, 16'h0010, 16'h0001, 0);
      @(posedge clk);
      #1;
      check(test_mode, MSTL_MODE_LOOP);
      i_sim.end_pulse(2);
      settle(50);
      check(done_cnt, 4);
      check(test_active, 0);
      close_out;
   end
endmodule : mstl_engine_test

// >>> mstl_pkg.sv
// Package for the packet test-mode loopback engine.
// Assumes one 125 MHz clock and an active-low asynchronous reset.
package mstl_pkg;

   localparam int unsigned PAYLOAD_W = 8;
   localparam int unsigned NUM_TN = 8;
   localparam int unsigned TN_W = 3;
   localparam int unsigned PDU_COUNT_W = 16;
   localparam int unsigned PDU_OCTETS_W = 16;
   localparam int unsigned LFSR_W = 15;
   localparam logic [14:0] LFSR_SEED = 15'h7FFF;
   localparam int unsigned LFSR_TAP_HI = 14;
   localparam int unsigned LFSR_TAP_LO = 13;
   localparam logic [3:0] CV_FROZEN = 4'hF;
   localparam logic [3:0] CV_LAST = 4'h0;
   localparam logic [3:0] CV_MAX = 4'hE;

   typedef enum logic {
      MSTL_MODE_PRBS,
      MSTL_MODE_LOOP
   } mstl_mode_t;

   // Test-mode command as delivered by the layer-3 parser
   typedef struct packed {
      logic mode_select;
      logic [TN_W-1:0] dl_tn_offset;
      logic multislot_en;
      logic [PDU_COUNT_W-1:0] pdu_count;
      logic [PDU_OCTETS_W-1:0] pdu_octets;
   } mstl_cmd_t;

   // Downlink block as delivered by layer 1
   typedef struct packed {
      logic [TN_W-1:0] tn;
      logic is_control;
      logic crc_ok;
      logic [PAYLOAD_W-1:0] data;
      logic last;
   } mstl_dl_t;

   // Uplink payload octet toward the MAC
   typedef struct packed {
      logic [TN_W-1:0] tn;
      logic [3:0] cv;
      logic [PAYLOAD_W-1:0] data;
      logic last;
   } mstl_ul_t;

endpackage : mstl_pkg

// >>> mstl_prbs.sv
// Pseudorandom octet source for the uplink payload.
// Assumes the caller pulses step once per octet it wants advanced; unstepped reads repeat the octet.
`timescale 1ns/1ps
module mstl_prbs
   import mstl_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic step,
   output logic [PAYLOAD_W-1:0] octet
);

   logic [LFSR_W-1:0] lfsr;
   logic [LFSR_W-1:0] chain [0:PAYLOAD_W];

   assign chain[0] = lfsr;

   // One shift per payload bit, eight per octet
   genvar gi;
   generate
      for (gi = 0; gi < PAYLOAD_W; gi++) begin : g_bit
         assign chain[gi+1] = {chain[gi][LFSR_W-2:0],
            chain[gi][LFSR_TAP_HI] ^ chain[gi][LFSR_TAP_LO]};
         assign octet[PAYLOAD_W-1-gi] = chain[gi][LFSR_W-1];
      end
   endgenerate

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lfsr <= LFSR_SEED;
      end else if (step) begin
         lfsr <= chain[PAYLOAD_W];
      end
   end

   lfsr_never_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
      lfsr != '0) else $error("generator locked at zero");

endmodule : mstl_prbs

// >>> mstl_sim_model.sv
// Test-equipment model: commands, downlink octets, grants, releases.
// Assumes the engine samples these on the rising edge of clk.
`timescale 1ns/1ps
module mstl_sim_model
   import mstl_pkg::*;
(
   input wire logic clk,
   input wire logic test_active,
   output logic cmd_valid,
   output mstl_cmd_t cmd,
   output logic dl_valid,
   output mstl_dl_t dl,
   output logic ul_grant,
   output logic [TN_W-1:0] ul_grant_tn,
   output logic ul_ctrl_send,
   output logic tbf_release,
   output logic dl_tbf_end,
   output logic pdch_release
);
   initial begin
      {cmd_valid, cmd, dl_valid, dl, ul_grant, ul_grant_tn} = '0;
      {ul_ctrl_send, tbf_release, dl_tbf_end, pdch_release} = '0;
   end
   ////////////////////////////////////////////////////////////////////
   task send_cmd(input logic m, input logic [2:0] off, input logic ms,
         input logic [15:0] cnt, input logic [15:0] oct, input bit anyway);
      while (!anyway && test_active) @(posedge clk);
      @(posedge clk);
      #1;
      cmd = '{m, off, ms, cnt, oct};
      cmd_valid = 1'b1;
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      cmd = ~cmd;
   endtask : send_cmd
   // Drives one downlink octet, marked last, for a single clock
   task send_dl(input logic [2:0] tn, input logic ctl, input logic crc,
         input logic [7:0] d);
      @(posedge clk);
      #1;
      dl = '{tn, ctl, crc, d, 1'b1};
      dl_valid = 1'b1;
      @(posedge clk);
      #1;
      dl_valid = 1'b0;
      dl = ~dl;
   endtask : send_dl
   task grant(input logic [2:0] tn, input logic ctl);
      @(posedge clk);
      #1;
      {ul_grant, ul_grant_tn, ul_ctrl_send} = {1'b1, tn, ctl};
      @(posedge clk);
      #1;
      {ul_grant, ul_grant_tn, ul_ctrl_send} = {1'b0, ~tn, 1'b0};
   endtask : grant
   // Ends the test: 0 TBF release, 1 downlink end, 2 channel release
   task end_pulse(input int which);
      @(posedge clk);
      #1;
      {tbf_release, dl_tbf_end, pdch_release} = 3'h4 >> which;
      @(posedge clk);
      #1;
      {tbf_release, dl_tbf_end, pdch_release} = 3'h0;
   endtask : end_pulse
endmodule : mstl_sim_model
